// >>> common/tsr_pkg.sv
// Package with register map, field layout and encodings of the tuner status readback block.
package tsr_pkg;
  localparam int unsigned TSR_AW = 5;
  localparam int unsigned TSR_DW = 16;
  // Register offsets.
  localparam logic [4:0] TSR_OFF_SCAN_CTRL = 5'h02;
  localparam logic [4:0] TSR_OFF_TARGET_STATION_CTRL = 5'h03;
  localparam logic [4:0] TSR_OFF_PIN_CFG = 5'h04;
  localparam logic [4:0] TSR_OFF_BAND_CFG = 5'h05;
  localparam logic [4:0] TSR_OFF_STATUS = 5'h0A;
  localparam logic [4:0] TSR_OFF_CHANNEL = 5'h0B;
  localparam logic [4:0] TSR_OFF_IRQ_STAT = 5'h10;
  localparam logic [4:0] TSR_OFF_IRQ_MASK = 5'h11;
  localparam logic [15:0] TSR_RST_VAL = 16'h0000;
  // Field positions.
  localparam int unsigned TSR_B_GROUP_READY = 15;
  localparam int unsigned TSR_B_SEEK_TUNE_DONE = 14;
  localparam int unsigned TSR_B_SEEK_FAIL = 13;
  localparam int unsigned TSR_B_RAILED = 12;
  localparam int unsigned TSR_B_SYNC = 11;
  localparam int unsigned TSR_B_BLK_A_LO = 9;
  localparam int unsigned TSR_B_STEREO = 8;
  localparam int unsigned TSR_B_BLK_B_LO = 14;
  localparam int unsigned TSR_B_BLK_C_LO = 12;
  localparam int unsigned TSR_B_BLK_D_LO = 10;
  localparam int unsigned TSR_B_SCAN_REQ = 8;
  localparam int unsigned TSR_B_WRAP = 10;
  localparam int unsigned TSR_B_VERBOSE = 11;
  localparam int unsigned TSR_B_TARGET_STATION_SET = 15;
  localparam int unsigned TSR_B_PIN3_LO = 4;
  localparam int unsigned TSR_B_SPACE_LO = 4;
  localparam int unsigned TSR_B_RANGE_LO = 6;
  localparam int unsigned TSR_TARGET_STATION_W = 10;
  localparam int unsigned TSR_IRQ_W = 4;
  // Interrupt status bit positions.
  localparam int unsigned TSR_I_DONE = 0;
  localparam int unsigned TSR_I_FAIL = 1;
  localparam int unsigned TSR_I_GROUP = 2;
  localparam int unsigned TSR_I_RAIL = 3;
  // Encodings.
  localparam logic [1:0] TSR_PIN3_STEREO = 2'h1;
  localparam logic [1:0] TSR_RANGE_WIDE = 2'h0;
  localparam logic [1:0] TSR_ERR_NONE = 2'h0;
  localparam logic [1:0] TSR_ERR_LOW = 2'h1;
  localparam logic [1:0] TSR_ERR_MID = 2'h2;
  localparam logic [1:0] TSR_ERR_HIGH = 2'h3;
  localparam logic [2:0] TSR_ERR_LOW_MAX = 3'h2;
  localparam logic [2:0] TSR_ERR_MID_MAX = 3'h5;
  localparam logic [7:0] TSR_STRENGTH_MAX = 8'h4B;
  // Frequencies in units of 10 kHz: 87.5 MHz and 76 MHz bases, steps of 200/100/50 kHz.
  localparam logic [15:0] TSR_BASE_WIDE = 16'h222E;
  localparam logic [15:0] TSR_BASE_LOW = 16'h1DB0;
  localparam logic [4:0] TSR_STEP_200K = 5'h14;
  localparam logic [4:0] TSR_STEP_100K = 5'h0A;
  localparam logic [4:0] TSR_STEP_50K = 5'h05;
  localparam logic [1:0] TSR_SPACE_200K = 2'h0;
  localparam logic [1:0] TSR_SPACE_100K = 2'h1;
endpackage

// >>> design/tsr_status_regs.sv
// Status and channel readback register bank of the FM tuner with its control inputs.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Status bit 15 is high while a new radio-data group is ready, one enabled cycle late.
// - Status bit 14 is set when a seek or tune operation finishes.
// - Bit 14 is cleared when the scan request or channel set request bit is taken low.
// - In non-wrap mode the seek fail flag is set when a seek finds no qualifying channel.
// - In wrap mode the seek fail flag is set when the seek reaches a band edge.
// - The seek fail flag is cleared only by taking the scan request bit low.
// - Status bit 12 marks a railed frequency control and softmutes audio while set.
// - The railed flag is refreshed at seek or tune completion and tracks during reception.
// - Status bit 11 shows decoder sync, and reads zero outside verbose mode.
// - In verbose mode each block error field encodes 0, 1-2, 3-5, or 6+ and uncorrectable errors.
// - Block A errors sit at status 10:9, blocks B, C, D at channel bits 15:14, 13:12, 11:10.
// - Status bit 8 is the stereo flag, also driven on pin 3 when its select is 01.
// - Status bits 7:0 hold signal strength in dB steps, never above 75.
// - With range 00 the frequency is spacing times channel plus 87.5 MHz.
// - With range 01 or 10 the frequency is spacing times channel plus 76 MHz.
// - Channel bits 9:0 follow the tuned channel during a seek and at completion.
module tsr_status_regs
  import tsr_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic [4:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  input wire logic GROUP_READY,
  input wire logic OP_DONE,
  input wire logic SEEK_NO_VALID,
  input wire logic SEEK_AT_EDGE,
  input wire logic RAIL_IN,
  input wire logic SYNC_IN,
  input wire logic [11:0] BLK_ERR_CNT,
  input wire logic [3:0] BLK_UNCORR,
  input wire logic STEREO_IN,
  input wire logic [7:0] STRENGTH_IN,
  input wire logic TARGET_STATION_STEP,
  input wire logic [9:0] TARGET_STATION_IN,
  output logic SOFTMUTE,
  output logic [15:0] FREQ_10KHZ,
  output logic PIN3_OUT,
  output logic PIN3_OE,
  input wire logic PIN3_IN,
  output logic IRQ
);

  logic [15:0] scan_ctrl_q;
  logic [15:0] target_station_ctrl_q;
  logic [15:0] pin_cfg_q;
  logic [15:0] band_cfg_q;
  logic group_q;
  logic done_q;
  logic fail_q;
  logic rail_q;
  logic sync_q;
  logic stereo_q;
  logic [7:0] strength_q;
  logic [7:0] err_q;
  logic [9:0] target_station_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic [15:0] rdata_q;
  logic [15:0] freq_q;
  logic [15:0] status_word;
  logic [15:0] channel_word;
  logic wr_scan;
  logic wr_target_station;
  logic scan_fall;
  logic target_station_set_fall;
  logic verbose;
  logic fail_ev;
  logic [3:0] irq_ev;
  logic [7:0] err_enc;
  logic [15:0] step;
  logic [15:0] base;

  // Unused by the bank; the pin is output-only in stereo mode.
  logic pin3_unused;
  assign pin3_unused = PIN3_IN;

  function automatic logic [1:0] tsr_err_code(input logic [2:0] cnt, input logic uncorr);
    logic [1:0] code;
    code = TSR_ERR_HIGH;
    if (uncorr) begin
      code = TSR_ERR_HIGH;
    end else if (cnt == 3'h0) begin
      code = TSR_ERR_NONE;
    end else if (cnt <= TSR_ERR_LOW_MAX) begin
      code = TSR_ERR_LOW;
    end else if (cnt <= TSR_ERR_MID_MAX) begin
      code = TSR_ERR_MID;
    end
    return code;
  endfunction

  for (genvar g = 0; g < 4; g++) begin : g_err
    assign err_enc[2*g +: 2] = tsr_err_code(BLK_ERR_CNT[3*g +: 3], BLK_UNCORR[g]);
  end

  assign wr_scan = REG_WR && (REG_ADDR == TSR_OFF_SCAN_CTRL);
  assign wr_target_station = REG_WR && (REG_ADDR == TSR_OFF_TARGET_STATION_CTRL);
  // A request bit is taken low by a write that clears a bit which was set.
  assign scan_fall = wr_scan && scan_ctrl_q[TSR_B_SCAN_REQ] && !REG_WDATA[TSR_B_SCAN_REQ];
  assign target_station_set_fall = wr_target_station && target_station_ctrl_q[TSR_B_TARGET_STATION_SET] && !REG_WDATA[TSR_B_TARGET_STATION_SET];
  assign verbose = scan_ctrl_q[TSR_B_VERBOSE];
  assign fail_ev = scan_ctrl_q[TSR_B_WRAP] ? SEEK_AT_EDGE : SEEK_NO_VALID;

  // Control registers that feed the status logic; the readback pair has no write path.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scan_ctrl_q <= TSR_RST_VAL;
      target_station_ctrl_q <= TSR_RST_VAL;
      pin_cfg_q <= TSR_RST_VAL;
      band_cfg_q <= TSR_RST_VAL;
    end else if (CLK_EN && REG_WR) begin
      unique case (REG_ADDR)
        TSR_OFF_SCAN_CTRL: scan_ctrl_q <= REG_WDATA;
        TSR_OFF_TARGET_STATION_CTRL: target_station_ctrl_q <= REG_WDATA;
        TSR_OFF_PIN_CFG: pin_cfg_q <= REG_WDATA;
        TSR_OFF_BAND_CFG: band_cfg_q <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // Completion and failure flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (CLK_EN) begin
      if (OP_DONE) begin
        done_q <= 1'b1;
      end else if (scan_fall || target_station_set_fall) begin
        done_q <= 1'b0;
      end
      if (fail_ev) begin
        fail_q <= 1'b1;
      end else if (scan_fall) begin
        fail_q <= 1'b0;
      end
    end
  end

  // Rail flag is frozen during a running operation so the host reads the settled result.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rail_q <= 1'b0;
    end else if (CLK_EN) begin
      if (OP_DONE || !(scan_ctrl_q[TSR_B_SCAN_REQ] || target_station_ctrl_q[TSR_B_TARGET_STATION_SET])) begin
        rail_q <= RAIL_IN;
      end
    end
  end

  // Live reception state sampled every enabled cycle.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      group_q <= 1'b0;
      sync_q <= 1'b0;
      stereo_q <= 1'b0;
      strength_q <= 8'h00;
      err_q <= 8'h00;
    end else if (CLK_EN) begin
      group_q <= GROUP_READY;
      sync_q <= SYNC_IN && verbose;
      err_q <= verbose ? err_enc : 8'h00;
      stereo_q <= STEREO_IN;
      strength_q <= (STRENGTH_IN > TSR_STRENGTH_MAX) ? TSR_STRENGTH_MAX : STRENGTH_IN;
    end
  end

  // Tuned channel follows the seek steps and the final result.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      target_station_q <= 10'h000;
    end else if (CLK_EN) begin
      if (OP_DONE || (TARGET_STATION_STEP && scan_ctrl_q[TSR_B_SCAN_REQ])) begin
        target_station_q <= TARGET_STATION_IN;
      end
    end
  end

  always_comb begin
    unique case (band_cfg_q[TSR_B_SPACE_LO +: 2])
      TSR_SPACE_200K: step = {11'h000, TSR_STEP_200K};
      TSR_SPACE_100K: step = {11'h000, TSR_STEP_100K};
      default: step = {11'h000, TSR_STEP_50K};
    endcase
    base = (band_cfg_q[TSR_B_RANGE_LO +: 2] == TSR_RANGE_WIDE) ? TSR_BASE_WIDE : TSR_BASE_LOW;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      freq_q <= 16'h0000;
    end else if (CLK_EN) begin
      freq_q <= 16'(step * {6'h00, target_station_q}) + base;
    end
  end

  assign status_word = {group_q, done_q, fail_q, rail_q, sync_q, err_q[1:0], stereo_q,
                        strength_q};
  assign channel_word = {err_q[3:2], err_q[5:4], err_q[7:6], target_station_q};

  // Interrupt status: write one to clear, a simultaneous event keeps the bit set.
  assign irq_ev[TSR_I_DONE] = OP_DONE;
  assign irq_ev[TSR_I_FAIL] = fail_ev;
  assign irq_ev[TSR_I_GROUP] = GROUP_READY && !group_q;
  assign irq_ev[TSR_I_RAIL] = RAIL_IN && !rail_q;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_stat_q <= 4'h0;
      irq_mask_q <= 4'h0;
    end else if (CLK_EN) begin
      if (REG_WR && REG_ADDR == TSR_OFF_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~REG_WDATA[TSR_IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
      if (REG_WR && REG_ADDR == TSR_OFF_IRQ_MASK) begin
        irq_mask_q <= REG_WDATA[TSR_IRQ_W-1:0];
      end
    end
  end

  // Read data stands only until the next enabled cycle after the strobe; the bank never stalls the host.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= 16'h0000;
    end else if (CLK_EN) begin
      rdata_q <= 16'h0000;
      if (REG_RD) begin
        unique case (REG_ADDR)
          TSR_OFF_SCAN_CTRL: rdata_q <= scan_ctrl_q;
          TSR_OFF_TARGET_STATION_CTRL: rdata_q <= target_station_ctrl_q;
          TSR_OFF_PIN_CFG: rdata_q <= pin_cfg_q;
          TSR_OFF_BAND_CFG: rdata_q <= band_cfg_q;
          TSR_OFF_STATUS: rdata_q <= status_word;
          TSR_OFF_CHANNEL: rdata_q <= channel_word;
          TSR_OFF_IRQ_STAT: rdata_q <= {12'h000, irq_stat_q};
          TSR_OFF_IRQ_MASK: rdata_q <= {12'h000, irq_mask_q};
          default: rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  assign REG_RDATA = rdata_q;
  assign SOFTMUTE = rail_q;
  assign FREQ_10KHZ = freq_q;
  assign PIN3_OE = (pin_cfg_q[TSR_B_PIN3_LO +: 2] == TSR_PIN3_STEREO);
  assign PIN3_OUT = stereo_q && PIN3_OE;
  assign IRQ = |(irq_stat_q & irq_mask_q);

  // Properties other than strength_cap_a and the covers look one cycle past their cause, since every flag they watch is registered.
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  group_level_a: assert property (CLK_EN |=> group_q == $past(GROUP_READY))
    else $error("group ready flag does not follow the core");
  done_set_a: assert property (CLK_EN && OP_DONE |=> done_q)
    else $error("seek tune done not set on completion");
  done_clear_a: assert property (CLK_EN && !OP_DONE && scan_fall |=> !done_q)
    else $error("seek tune done not cleared by request going low");
  done_target_station_clear_a: assert property (CLK_EN && !OP_DONE && target_station_set_fall |=> !done_q)
    else $error("seek tune done not cleared by channel set request going low");
  fail_nowrap_a: assert property (CLK_EN && !scan_ctrl_q[TSR_B_WRAP] && SEEK_NO_VALID
                                  |=> fail_q)
    else $error("seek fail not set on no valid channel");
  fail_wrap_a: assert property (CLK_EN && scan_ctrl_q[TSR_B_WRAP] && SEEK_AT_EDGE
                                |=> fail_q)
    else $error("seek fail not set at band edge");
  fail_hold_a: assert property (fail_q && !scan_fall |=> fail_q)
    else $error("seek fail cleared without scan request going low");
  mute_rail_a: assert property (CLK_EN && !scan_ctrl_q[TSR_B_SCAN_REQ]
                                && !target_station_ctrl_q[TSR_B_TARGET_STATION_SET] |=> SOFTMUTE == $past(RAIL_IN))
    else $error("softmute does not follow the rail flag");
  rail_done_a: assert property (CLK_EN && OP_DONE |=> rail_q == $past(RAIL_IN))
    else $error("rail flag not refreshed at completion");
  sync_gate_a: assert property (CLK_EN && !verbose
                                |=> !sync_q && status_word[TSR_B_BLK_A_LO +: 2] == TSR_ERR_NONE)
    else $error("sync reported outside verbose mode");
  err_uncorr_a: assert property (CLK_EN && verbose && BLK_UNCORR[0]
                                 |=> status_word[TSR_B_BLK_A_LO +: 2] == TSR_ERR_HIGH)
    else $error("uncorrectable block not reported as worst error level");
  freq_wide_a: assert property (CLK_EN
                                && band_cfg_q[TSR_B_RANGE_LO +: 2] == TSR_RANGE_WIDE
                                && band_cfg_q[TSR_B_SPACE_LO +: 2] == TSR_SPACE_200K
                                |=> FREQ_10KHZ == $past(TSR_BASE_WIDE + target_station_q * TSR_STEP_200K))
    else $error("frequency readout off in the wide band");
  strength_cap_a: assert property (strength_q <= TSR_STRENGTH_MAX)
    else $error("signal strength above cap");
  target_station_track_a: assert property (CLK_EN && OP_DONE |=> target_station_q == $past(TARGET_STATION_IN))
    else $error("channel not updated at completion");
  readback_wr_a: assert property (CLK_EN && REG_WR && REG_ADDR == TSR_OFF_CHANNEL
                                  && !OP_DONE && !TARGET_STATION_STEP |=> target_station_q == $past(target_station_q))
    else $error("write to channel readback register changed the channel");
  read_timing_a: assert property (CLK_EN && REG_RD && REG_ADDR == TSR_OFF_STATUS
                                  |=> REG_RDATA == $past(status_word))
    else $error("status read data wrong");
  pin3_a: assert property (CLK_EN |=> PIN3_OUT == ($past(STEREO_IN) && PIN3_OE))
    else $error("pin 3 does not show stereo");

  seek_done_c: cover property (CLK_EN && OP_DONE ##[1:20] scan_fall);
  fail_wrap_c: cover property (CLK_EN && scan_ctrl_q[TSR_B_WRAP] && SEEK_AT_EDGE);
  irq_c: cover property (IRQ ##1 !IRQ);
  rail_freeze_c: cover property (CLK_EN && scan_ctrl_q[TSR_B_SCAN_REQ] && RAIL_IN && !rail_q);
  err_worst_c: cover property (CLK_EN && verbose && (&BLK_UNCORR));

endmodule // tsr_status_regs
`default_nettype wire

// >>> verification/tsr_host_model.sv
// Host controller model that reaches the tuner registers over the plain register port.
`timescale 1ns/1ps
`default_nettype none
module tsr_host_model
  import tsr_pkg::*;
(
  input wire logic clk,
  output logic [4:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [15:0] rdata
);
  initial begin
    addr = 5'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Idle address and data turn to their inverse, so a design that reads them late fails.
  task automatic write(input logic [4:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    @(posedge clk);
  endtask
  task automatic read(input logic [4:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  // A request bit only counts as taken low when it was high just before.
  task automatic drop(input logic [4:0] a, input logic [15:0] keep, input int b);
    write(a, keep | (16'h0001 << b));
    write(a, keep & ~(16'h0001 << b));
  endtask
endmodule // tsr_host_model
`default_nettype wire

// >>> verification/tuner_status_readback_tb_top.sv
// Self-checking testbench of the tuner status readback register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(16'(g), 16'(e))
module tuner_status_readback_tb_top;
  import tsr_pkg::*;
  logic clk, rst_n, grp, done, nov, edg, rail, sync, ster, step, smute, p3o, p3oe, irq;
  logic [11:0] ecnt;
  logic [3:0] unc;
  logic [7:0] str;
  logic [9:0] chn;
  logic [15:0] d, rdata, wdata, freq;
  logic [4:0] addr;
  logic wr, rd, en;
  int failures = 0;
  int n_compared = 0;
  tsr_host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  tsr_status_regs dut (.CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(en), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .GROUP_READY(grp),
    .OP_DONE(done), .SEEK_NO_VALID(nov), .SEEK_AT_EDGE(edg), .RAIL_IN(rail), .SYNC_IN(sync),
    .BLK_ERR_CNT(ecnt), .BLK_UNCORR(unc), .STEREO_IN(ster), .STRENGTH_IN(str),
    .TARGET_STATION_STEP(step), .TARGET_STATION_IN(chn), .SOFTMUTE(smute), .FREQ_10KHZ(freq), .PIN3_OUT(p3o),
    .PIN3_OE(p3oe), .PIN3_IN(1'b0), .IRQ(irq));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic test_done();
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse(input int w);
    case (w)
      0: done <= 1'b1;
      1: nov <= 1'b1;
      2: edg <= 1'b1;
      default: step <= 1'b1;
    endcase
    tick(1);
    {done, nov, edg, step} <= 4'h0;
    tick(1);
  endtask
  function automatic logic [1:0] code(input int c);
    return c == 0 ? 2'h0 : c <= 2 ? 2'h1 : c <= 5 ? 2'h2 : 2'h3;
  endfunction
  task automatic t_reset();
    host.read(TSR_OFF_STATUS, d);
    `CHK(d, 16'h0000);
    host.read(TSR_OFF_CHANNEL, d);
    `CHK(d, 16'h0000);
    `CHK(freq, 16'h222E);
    host.write(5'h1F, 16'hFFFF);
    host.read(5'h1F, d);
    `CHK(d, 16'h0000);
  endtask
  task automatic t_done();
    chn <= 10'h155;
    pulse(0);
    host.read(TSR_OFF_STATUS, d);
    `CHK(d[14], 1'b1);
    `CHK(irq, 1'b0);
    host.write(TSR_OFF_STATUS, 16'h0000);
    host.write(TSR_OFF_CHANNEL, 16'hFFFF);
    host.read(TSR_OFF_STATUS, d);
    `CHK(d[14], 1'b1);
    host.read(TSR_OFF_CHANNEL, d);
    `CHK(d, 16'h0155);
    host.write(TSR_OFF_IRQ_MASK, 16'h0001);
    `CHK(irq, 1'b1);
    host.write(TSR_OFF_IRQ_STAT, 16'h0001);
    `CHK(irq, 1'b0);
    host.drop(TSR_OFF_TARGET_STATION_CTRL, 16'h0000, TSR_B_TARGET_STATION_SET);
    host.read(TSR_OFF_STATUS, d);
    `CHK(d[14], 1'b0);
    pulse(0);
    host.drop(TSR_OFF_SCAN_CTRL, 16'h0000, TSR_B_SCAN_REQ);
    host.read(TSR_OFF_STATUS, d);
    `CHK(d[14], 1'b0);
    host.write(TSR_OFF_IRQ_MASK, 16'h0000);
    chn <= 10'h02A;
    host.write(TSR_OFF_SCAN_CTRL, 16'h0100);
    pulse(3);
    host.read(TSR_OFF_CHANNEL, d);
    `CHK(d[9:0], 10'h02A);
  endtask
  task automatic t_fail();
    host.write(TSR_OFF_SCAN_CTRL, 16'h0100);
    pulse(2);
    host.read(TSR_OFF_STATUS, d);
    `CHK(d[13], 1'b0);
    pulse(1);
    host.read(TSR_OFF_STATUS, d);
    `CHK(d[13], 1'b1);
    host.drop(TSR_OFF_TARGET_STATION_CTRL, 16'h0000, TSR_B_TARGET_STATION_SET);
    host.read(TSR_OFF_STATUS, d);
    `CHK(d[13], 1'b1);
    host.drop(TSR_OFF_SCAN_CTRL, 16'h0400, TSR_B_SCAN_REQ);
    host.read(TSR_OFF_STATUS, d);
    `CHK(d[13], 1'b0);
    pulse(1);
    host.read(TSR_OFF_STATUS, d);
    `CHK(d[13], 1'b0);
    pulse(2);
    host.read(TSR_OFF_STATUS, d);
    `CHK(d[13], 1'b1);
    host.drop(TSR_OFF_SCAN_CTRL, 16'h0000, TSR_B_SCAN_REQ);
  endtask
  task automatic t_rail();
    rail <= 1'b1;
    tick(2);
    `CHK(smute, 1'b1);
    host.read(TSR_OFF_STATUS, d);
    `CHK(d[12], 1'b1);
    rail <= 1'b0;
    tick(2);
    `CHK(smute, 1'b0);
    host.write(TSR_OFF_SCAN_CTRL, 16'h0100);
    rail <= 1'b1;
    tick(2);
    `CHK(smute, 1'b0);
    pulse(0);
    tick(1);
    `CHK(smute, 1'b1);
    rail <= 1'b0;
    host.drop(TSR_OFF_SCAN_CTRL, 16'h0000, TSR_B_SCAN_REQ);
  endtask
  task automatic t_verbose();
    sync <= 1'b1;
    ecnt <= 12'hFFF;
    tick(1);
    host.read(TSR_OFF_STATUS, d);
    `CHK(d[11:9], 3'h0);
    host.write(TSR_OFF_SCAN_CTRL, 16'h0800);
    host.read(TSR_OFF_STATUS, d);
    `CHK(d[11], 1'b1);
    for (int c = 0; c < 9; c++) begin
      ecnt <= c < 8 ? {3'(7 - c), 3'(c), 3'(7 - c), 3'(c)} : 12'h000;
      unc <= c < 8 ? 4'h0 : 4'hF;
      tick(1);
      host.read(TSR_OFF_STATUS, d);
      `CHK(d[10:9], code(c));
      host.read(TSR_OFF_CHANNEL, d);
      `CHK(d[15:10], {code(c < 8 ? 7 - c : c), code(c), code(c < 8 ? 7 - c : c)});
    end
    host.write(TSR_OFF_SCAN_CTRL, 16'h0000);
  endtask
  task automatic t_misc();
    {grp, ster} <= 2'h3;
    str <= 8'h64;
    tick(1);
    host.read(TSR_OFF_STATUS, d);
    `CHK({d[15], d[8]}, 2'h3);
    `CHK(d[7:0], 8'h4B);
    `CHK(p3oe, 1'b0);
    host.write(TSR_OFF_PIN_CFG, 16'h0010);
    `CHK({p3oe, p3o}, 2'h3);
    {grp, ster} <= 2'h0;
    str <= 8'h28;
    tick(2);
    `CHK(p3o, 1'b0);
    host.read(TSR_OFF_STATUS, d);
    `CHK({d[15], d[8], d[7:0]}, 10'h028);
    host.write(TSR_OFF_PIN_CFG, 16'h0020);
    `CHK(p3oe, 1'b0);
  endtask
  task automatic t_freq();
    logic [15:0] cfg [3] = '{16'h0000, 16'h0050, 16'h00A0};
    int base [3] = '{8750, 7600, 7600};
    int stp [3] = '{20, 10, 5};
    int ch [3] = '{200, 511, 1023};
    for (int i = 0; i < 3; i++) begin
      host.write(TSR_OFF_BAND_CFG, cfg[i]);
      chn <= 10'(ch[i]);
      pulse(0);
      tick(2);
      `CHK(freq, base[i] + stp[i] * ch[i]);
    end
  endtask
  // A low clock enable must swallow a completion pulse without a trace.
  task automatic t_freeze();
    host.drop(TSR_OFF_TARGET_STATION_CTRL, 16'h0000, TSR_B_TARGET_STATION_SET);
    en <= 1'b0;
    pulse(0);
    en <= 1'b1;
    host.read(TSR_OFF_STATUS, d);
    `CHK(d[14], 1'b0);
    pulse(0);
    host.read(TSR_OFF_STATUS, d);
    `CHK(d[14], 1'b1);
  endtask
  // The tests need well under a thousand cycles, so this bound only trips on a hang.
  initial begin
    #2000000;
    failures++;
    test_done();
  end
  initial begin
    {rst_n, grp, done, nov, edg, rail, sync, ster, step} = 9'h000;
    {ecnt, unc, str, chn} = 34'h0;
    en = 1'b1;
    tick(10);
    rst_n <= 1'b1;
    tick(2);
    t_reset();
    t_done();
    t_fail();
    t_rail();
    t_verbose();
    t_misc();
    t_freq();
    t_freeze();
    test_done();
  end
endmodule // tuner_status_readback_tb_top
`default_nettype wire
